// ---- logic/charger_ctrl.v ----
// power-up sequencing, charge enable, soft-start and pwm protection logic of the charger
`timescale 1ns/100ps
`include "charger_map.vh"
module charger_ctrl #(
  parameter ADAPTER_GOOD_CYC = `ADAPTER_GOOD_CYC,
  parameter ALLOW_DELAY_CYC  = `ALLOW_DELAY_CYC,
  parameter SS_STEP_CYC      = `SS_STEP_CYC,
  parameter PWM_PERIOD_CYC   = `PWM_PERIOD_CYC,
  parameter REFRESH_CYC      = `REFRESH_CYC
) (
  input  wire       clock_i,
  input  wire       nrst_i,
  input  wire       supply_above_4v_i,
  input  wire       supply_above_4v5_i,
  input  wire       adapter_above_0v6_i,
  input  wire       adapter_above_2v4_i,
  input  wire       bus_supply_above_2v5_i,
  input  wire       bus_supply_above_2v35_i,
  input  wire       adapter_batt_ok_i,
  input  wire [2:0] limits_valid_i,
  input  wire       charge_allow_i,
  input  wire       gate_drive_valid_i,
  input  wire       ref_valid_i,
  input  wire       die_above_155c_i,
  input  wire       die_below_135c_i,
  input  wire       batt_overvoltage_i,
  input  wire       error_above_ramp_i,
  input  wire       boot_low_i,
  input  wire       undercurrent_i,
  input  wire       peak_overcurrent_i,
  input  wire       avg_overcurrent_i,
  input  wire       current_limit_low_i,
  output reg        ref_enable_o,
  output reg        current_monitor_en_o,
  output reg        adapter_good_out_o,
  output reg        gate_drive_enable_o,
  output reg        charging_o,
  output reg  [3:0] soft_start_step_o,
  output reg        ocp_fixed_sel_o,
  output reg        high_side_on_o,
  output reg        low_side_on_o
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronised comparator flags
  wire       s_4v;
  wire       s_4v5;
  wire       s_ad06;
  wire       s_ad24;
  wire       s_bus25;
  wire       s_bus235;
  wire       s_batt_ok;
  wire [2:0] s_limits;
  wire       s_allow;
  wire       s_gd_ok;
  wire       s_ref_ok;
  wire       s_hot;
  wire       s_cool;
  wire       s_ovp;
  wire       s_err_hi;
  wire       s_boot_low;
  wire       s_under;
  wire       s_peak_oc;
  wire       s_avg_oc;
  wire       s_ilim_low;

  // every analog decision passes two flops before logic sees it
  flag_sync #(
    .WIDTH (22)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     ({supply_above_4v_i, supply_above_4v5_i, adapter_above_0v6_i,
                adapter_above_2v4_i, bus_supply_above_2v5_i, bus_supply_above_2v35_i,
                adapter_batt_ok_i, limits_valid_i, charge_allow_i, gate_drive_valid_i,
                ref_valid_i, die_above_155c_i, die_below_135c_i, batt_overvoltage_i,
                error_above_ramp_i, boot_low_i, undercurrent_i, peak_overcurrent_i,
                avg_overcurrent_i, current_limit_low_i}),
    .q_o     ({s_4v, s_4v5, s_ad06, s_ad24, s_bus25, s_bus235, s_batt_ok, s_limits,
                s_allow, s_gd_ok, s_ref_ok, s_hot, s_cool, s_ovp, s_err_hi, s_boot_low,
                s_under, s_peak_oc, s_avg_oc, s_ilim_low})
  );

  //////////////////////////////////////////////////////////////////////////////
  // supply lockouts with hysteresis and thermal latch
  reg supply_ok_q;
  reg bus_ok_q;
  reg thermal_q;

  // hysteresis keeps a slowly sagging rail from chattering the charger
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      supply_ok_q <= 1'b0;
      bus_ok_q    <= 1'b0;
      thermal_q   <= 1'b0;
    end else begin
      if (!s_4v)
        supply_ok_q <= 1'b0;
      else if (s_4v5)
        supply_ok_q <= 1'b1;
      if (!s_bus235)
        bus_ok_q <= 1'b0;
      else if (s_bus25)
        bus_ok_q <= 1'b1;
      // a hot die wins over the cool flag should both be seen
      if (s_hot)
        thermal_q <= 1'b1;
      else if (s_cool)
        thermal_q <= 1'b0;
    end
  end

  wire bias_on  = supply_ok_q & s_ad06;
  wire detected = bias_on & s_ad24;

  //////////////////////////////////////////////////////////////////////////////
  // adapter-good delay and charge-allow delay
  reg [19:0] ag_cnt_q;
  reg        ag_q;
  reg [19:0] al_cnt_q;
  reg        al_done_q;

  // both timers restart whenever their qualifying condition drops
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ag_cnt_q  <= `CNT_ZERO;
      ag_q      <= 1'b0;
      al_cnt_q  <= `CNT_ZERO;
      al_done_q <= 1'b0;
    end else begin
      if (!detected) begin
        ag_cnt_q <= `CNT_ZERO;
        ag_q     <= 1'b0;
      end else if (ag_cnt_q == ADAPTER_GOOD_CYC[19:0] - `CNT_ONE) begin
        ag_q <= 1'b1;
      end else begin
        ag_cnt_q <= ag_cnt_q + `CNT_ONE;
      end
      if (!(ag_q & s_allow)) begin
        al_cnt_q  <= `CNT_ZERO;
        al_done_q <= 1'b0;
      end else if (al_cnt_q == ALLOW_DELAY_CYC[19:0] - `CNT_ONE) begin
        al_done_q <= 1'b1;
      end else begin
        al_cnt_q <= al_cnt_q + `CNT_ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // charge enable
  wire gd_en    = s_4v5 & s_ad24 & s_allow & supply_ok_q & ~thermal_q;
  wire start_ok = supply_ok_q & s_4v5 & bus_ok_q & ag_q & s_batt_ok & (&s_limits) &
                  s_allow & al_done_q & s_gd_ok & s_ref_ok & ~thermal_q & ~s_ovp;
  wire stop     = ~(&s_limits) | ~s_allow | ~supply_ok_q | ~bus_ok_q | ~s_batt_ok |
                  s_ovp | thermal_q | ~ag_q;
  reg  chg_q;
  wire chg_d    = chg_q ? ~stop : start_ok;

  //////////////////////////////////////////////////////////////////////////////
  // soft-start ramp
  reg [19:0] ss_cnt_q;
  reg [3:0]  step_q;

  // next step, so the output shows step one on the very edge that charging starts
  wire [3:0] step_d = !chg_d ? `STEP_ZERO :
                      !chg_q ? 4'h1 :
                      (step_q != `SS_STEPS && ss_cnt_q == SS_STEP_CYC[19:0] - `CNT_ONE) ?
                      step_q + 4'h1 : step_q;

  // the ramp only runs from zero at enable; limit changes later bypass it
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ss_cnt_q <= `CNT_ZERO;
      step_q   <= `STEP_ZERO;
    end else if (!chg_d) begin
      ss_cnt_q <= `CNT_ZERO;
      step_q   <= `STEP_ZERO;
    end else if (!chg_q) begin
      ss_cnt_q <= `CNT_ZERO;
      step_q   <= 4'h1;
    end else if (step_q != `SS_STEPS) begin
      if (ss_cnt_q == SS_STEP_CYC[19:0] - `CNT_ONE) begin
        ss_cnt_q <= `CNT_ZERO;
        step_q   <= step_q + 4'h1;
      end else begin
        ss_cnt_q <= ss_cnt_q + `CNT_ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pwm cycle, bootstrap refresh and cycle latches
  reg [8:0] cyc_q;
  reg [1:0] boot_cnt_q;
  reg [3:0] ref_cnt_q;
  reg       hs_latch_q;
  reg       ls_latch_q;

  wire cyc_start = (cyc_q == 9'h000);
  wire cyc_last  = (cyc_q == PWM_PERIOD_CYC[8:0] - 9'h001);
  wire refresh   = (ref_cnt_q != 4'h0);
  wire boot_trip = cyc_start & s_boot_low & (boot_cnt_q == `BOOT_LOW_CYCLES);

  // the last clock of each period is always off: that is the duty cap
  wire hs_d = chg_d & ~refresh & ~boot_trip & ~hs_latch_q & ~s_peak_oc & ~s_avg_oc &
              s_err_hi & ~cyc_last;
  wire ls_d = chg_d & (refresh | boot_trip |
              (~hs_d & ~ls_latch_q & ~(low_side_on_o & s_under)));

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_q      <= 9'h000;
      boot_cnt_q <= 2'h0;
      ref_cnt_q  <= 4'h0;
      hs_latch_q <= 1'b0;
      ls_latch_q <= 1'b0;
    end else begin
      // free-running period, independent of any analog level
      cyc_q <= cyc_last ? 9'h000 : cyc_q + 9'h001;
      if (cyc_start) begin
        if (!s_boot_low || boot_trip)
          boot_cnt_q <= 2'h0;
        else
          boot_cnt_q <= boot_cnt_q + 2'h1;
      end
      if (boot_trip)
        ref_cnt_q <= REFRESH_CYC[3:0] - 4'h1;
      else if (refresh)
        ref_cnt_q <= ref_cnt_q - 4'h1;
      // once high-side ends in a cycle it stays off until the next begins
      if (cyc_last)
        hs_latch_q <= 1'b0;
      else if (s_peak_oc | (high_side_on_o & ~hs_d))
        hs_latch_q <= 1'b1;
      if (cyc_last)
        ls_latch_q <= 1'b0;
      else if (low_side_on_o & s_under)
        ls_latch_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_enable_o         <= 1'b0;
      current_monitor_en_o <= 1'b0;
      adapter_good_out_o   <= 1'b0;
      gate_drive_enable_o  <= 1'b0;
      charging_o           <= 1'b0;
      chg_q                <= 1'b0;
      soft_start_step_o    <= `STEP_ZERO;
      ocp_fixed_sel_o      <= 1'b0;
      high_side_on_o       <= 1'b0;
      low_side_on_o        <= 1'b0;
    end else begin
      ref_enable_o         <= bias_on;
      current_monitor_en_o <= bias_on;
      adapter_good_out_o   <= ag_q;
      gate_drive_enable_o  <= gd_en;
      chg_q                <= chg_d;
      charging_o           <= chg_d;
      soft_start_step_o    <= step_d;
      ocp_fixed_sel_o      <= s_ilim_low;
      high_side_on_o       <= hs_d;
      low_side_on_o        <= ls_d & ~hs_d;
    end
  end
endmodule

// ---- logic/charger_map.vh ----
// constants and timing figures of the charger enable, soft-start and pwm guard logic
// Overview of operation
// - supply input below 4 V keeps everything disabled.
// - adapter below 0.6 V with supply above 4.5 V: adapter-good and current monitor low.
// - adapter above 0.6 V and supply above 4.5 V enables reference and bias.
// - adapter-good rises 100 us after adapter passes 2.4 V; charger may then start.
// - charging starts only when every enable condition holds.
// - 2 ms must pass after adapter detected and charge-allow high before charging.
// - any stop condition ends ongoing charging at once.
// - each enable ramps the current target up in 8 equal steps.
// - each soft-start step lasts about 1.6 ms.
// - limit changes during charging apply at once, no ramp repeat.
// - pwm cycle runs at a fixed 700 kHz.
// - duty follows error versus ramp; high-side duty capped at 356 of 357 clocks, about 99.72 percent.
// - bootstrap low for more than 3 cycles forces a 40 ns low-side refresh.
// - after refresh return to full-on; refresh again whenever bootstrap falls low.
// - undercurrent while low-side on latches low-side off until next cycle.
// - peak overcurrent latches high-side off until next cycle.
// - average overcurrent gates high-side; threshold 145 percent or fixed 5 A.
// - gate drive supply needs supply above 4.5 V, adapter above 2.4 V, allow high.
// - thermal shutdown holds charger off until die cools below 135 C.
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH

`define CLK_FREQ_KHZ       250000
`define CLK_PERIOD_PS      4000
`define PWM_FREQ_KHZ       700
`define T_ADAPTER_GOOD_NS  100000
`define T_ALLOW_DELAY_NS   2000000
`define T_SS_STEP_NS       1600000
`define T_REFRESH_NS       40
`define SS_STEPS           8
`define BOOT_LOW_CYCLES    3

// least times round up, the pwm period rounds down
`define NS_TO_CYC_UP(t)    (((t) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ADAPTER_GOOD_CYC   `NS_TO_CYC_UP(`T_ADAPTER_GOOD_NS)
`define ALLOW_DELAY_CYC    `NS_TO_CYC_UP(`T_ALLOW_DELAY_NS)
`define SS_STEP_CYC        `NS_TO_CYC_UP(`T_SS_STEP_NS)
`define REFRESH_CYC        `NS_TO_CYC_UP(`T_REFRESH_NS)
`define PWM_PERIOD_CYC     (`CLK_FREQ_KHZ / `PWM_FREQ_KHZ)

`define SYNC_RESET_VAL     1'b0
`define STEP_ZERO          4'h0
`define CNT_ONE            20'h00001
`define CNT_ZERO           20'h00000

`endif

// ---- logic/flag_sync.v ----
// two-flop synchroniser bank for comparator flags
`timescale 1ns/100ps
`include "charger_map.vh"
module flag_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage is read by the second stage only
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= {WIDTH{`SYNC_RESET_VAL}};
      sync_q <= {WIDTH{`SYNC_RESET_VAL}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ---- test/charger_ctrl_properties.sv ----
// port assertions for the charger control block
`timescale 1ns/100ps
module charger_ctrl_properties (
  input wire       clock_i,
  input wire       nrst_i,
  input wire       supply_above_4v_i,
  input wire       adapter_above_0v6_i,
  input wire       charge_allow_i,
  input wire       die_above_155c_i,
  input wire       avg_overcurrent_i,
  input wire       current_monitor_en_o,
  input wire       gate_drive_enable_o,
  input wire       charging_o,
  input wire [3:0] soft_start_step_o,
  input wire       high_side_on_o,
  input wire       low_side_on_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // flags take three edges to an output; supply and thermal pass a latch, so one edge more
  a_supply_low_off: assert property (!supply_above_4v_i [*5] |-> !charging_o && !gate_drive_enable_o)
    else $error("active with supply low");
  a_adapter_low_quiet: assert property (!adapter_above_0v6_i [*4] |-> !current_monitor_en_o)
    else $error("monitor on without adapter");
  a_allow_low_stop: assert property (!charge_allow_i [*4] |-> !charging_o && !gate_drive_enable_o)
    else $error("active with allow low");
  a_thermal_stop: assert property (die_above_155c_i [*5] |-> !charging_o && !gate_drive_enable_o)
    else $error("active while hot");
  a_step_first: assert property ($rose(charging_o) |-> soft_start_step_o == 4'h1)
    else $error("ramp not at first step");
  a_step_climb: assert property (charging_o && $past(charging_o) && $changed(soft_start_step_o)
    |-> soft_start_step_o == $past(soft_start_step_o) + 4'h1)
    else $error("ramp skipped a step");
  a_gates_apart: assert property (!(high_side_on_o && low_side_on_o))
    else $error("both gates on");
  a_avg_gate: assert property (avg_overcurrent_i [*4] |-> !high_side_on_o)
    else $error("high side on in overcurrent");
endmodule

// ---- test/power_stage_model.sv ----
// bootstrap model of the power stage feeding the low-bootstrap flag
`timescale 1ns/100ps
module power_stage_model #(
  parameter HOLD = 800
) (
  input  wire clock_i,
  input  wire nrst_i,
  input  wire low_side_on_i,
  output reg  boot_low_o
);
  integer on_q;
  integer idle_q;
  // the cap drains unless the low side stays on 8 clocks; a one-clock slot is not enough
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      on_q <= 0;
      idle_q <= 0;
      boot_low_o <= 1'b0;
    end else begin
      on_q <= low_side_on_i ? on_q + 1 : 0;
      idle_q <= (on_q >= 8) ? 0 : idle_q + 1;
      boot_low_o <= (idle_q > HOLD);
    end
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the charger control block
`timescale 1ns/100ps
module tb_top;
  localparam AG = 20, AD = 50, SS = 30, PP = 357, RF = 10;
  reg        clock_i, nrst_i, s4, s45, a06, a24, b25, b235, abok, alw, gdv, rfv;
  reg        hot, cool, ovp, ear, uc, poc, aoc, cll;
  reg  [2:0] lv;
  reg [31:0] rnd;
  wire       boot_low, ref_en, mon_en, good, gd_en, chg, fix_sel, hs, ls;
  wire [3:0] ss_step;
  integer    errors, tests_run, cyc, t0, n, k, r;
  charger_ctrl #(.ADAPTER_GOOD_CYC(AG), .ALLOW_DELAY_CYC(AD), .SS_STEP_CYC(SS),
    .PWM_PERIOD_CYC(PP), .REFRESH_CYC(RF)) i_charger_ctrl (
    .clock_i(clock_i), .nrst_i(nrst_i), .supply_above_4v_i(s4), .supply_above_4v5_i(s45),
    .adapter_above_0v6_i(a06), .adapter_above_2v4_i(a24), .bus_supply_above_2v5_i(b25),
    .bus_supply_above_2v35_i(b235), .adapter_batt_ok_i(abok), .limits_valid_i(lv),
    .charge_allow_i(alw), .gate_drive_valid_i(gdv), .ref_valid_i(rfv), .die_above_155c_i(hot),
    .die_below_135c_i(cool), .batt_overvoltage_i(ovp), .error_above_ramp_i(ear),
    .boot_low_i(boot_low), .undercurrent_i(uc), .peak_overcurrent_i(poc),
    .avg_overcurrent_i(aoc), .current_limit_low_i(cll), .ref_enable_o(ref_en),
    .current_monitor_en_o(mon_en), .adapter_good_out_o(good), .gate_drive_enable_o(gd_en),
    .charging_o(chg), .soft_start_step_o(ss_step), .ocp_fixed_sel_o(fix_sel),
    .high_side_on_o(hs), .low_side_on_o(ls));
  power_stage_model i_power_stage_model (.clock_i(clock_i), .nrst_i(nrst_i),
    .low_side_on_i(ls), .boot_low_o(boot_low));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // free cycle count is the pwm phase reference
  always @(posedge clock_i) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t flag %b not %b", $time, got, exp);
      end
    end
  endtask
  task chk_cyc(input integer got, input integer lo, input integer hi);
    begin
      tests_run = tests_run + 1;
      if (got < lo || got > hi) begin
        errors = errors + 1;
        $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clock_i);
      #1;
    end
  endtask
  function pick(input integer s);
    case (s)
      0: pick = ref_en;
      1: pick = good;
      2: pick = chg;
      3: pick = hs;
      default: pick = ls;
    endcase
  endfunction
  // bounded wait; running out ends the run
  task wait_on(input integer s, input v, input integer lim, output integer c);
    begin
      c = 0;
      while (pick(s) !== v && c < lim) begin
        tick;
        c = c + 1;
      end
      if (pick(s) !== v) begin
        errors = errors + 1;
        $display("[FAIL] %0t wait ran out", $time);
        end_sim;
      end
    end
  endtask
  task count_hs(output integer c);
    begin
      repeat (4) tick;
      c = 0;
      repeat (PP) begin
        tick;
        c = c + (hs !== 1'b0);
      end
    end
  endtask
  // xorshift source of random spacing and patterns
  function [31:0] xorshift(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
    end
  endfunction
  task rnd_wait;
    begin
      rnd = xorshift(rnd);
      repeat (20 + rnd % 200) tick;
    end
  endtask
  // one stop cause per index, broken or restored
  task set_cond(input integer k, input bad);
    case (k)
      // a random pattern with at least one limit out of range
      0: lv = bad ? (&rnd[2:0] ? 3'h6 : rnd[2:0]) : 3'h7;
      1: alw = !bad;
      2: {s4, s45} = bad ? 2'h0 : 2'h3;
      3: {b25, b235} = bad ? 2'h0 : 2'h3;
      4: abok = !bad;
      5: ovp = bad;
      default: begin
        hot = bad;
        cool = cool & !bad;
      end
    endcase
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {s4, s45, a06, a24, b25, b235, abok, alw, gdv, rfv, hot, cool, ovp} = 13'h0;
    {ear, uc, poc, aoc, cll} = 5'h0;
    lv = 3'h0;
    nrst_i = 1'b0;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    rnd = 32'h62;
    repeat (10) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    {s4, s45, b25, b235, abok, gdv, rfv, cool} = 8'hff;
    lv = 3'h7;
    repeat (6) tick;
    chk_bit(ref_en, 1'b0);
    chk_bit(mon_en, 1'b0);
    a06 = 1'b1;
    wait_on(0, 1'b1, 8, n);
    chk_cyc(n, 2, 4);
    chk_bit(good, 1'b0);
    a24 = 1'b1;
    wait_on(1, 1'b1, AG + 10, n);
    chk_cyc(n, AG, AG + 6);
    chk_bit(chg, 1'b0);
    alw = 1'b1;
    ear = 1'b1;
    wait_on(2, 1'b1, AD + 10, n);
    chk_cyc(n, AD, AD + 6);
    chk_bit(gd_en, 1'b1);
    // ramp climbs one step each SS cycles and then holds at full
    for (k = 1; k <= 8; k = k + 1) begin
      chk_bit(ss_step === k, 1'b1);
      n = 0;
      while (ss_step === k && n < SS + 2) begin
        tick;
        n = n + 1;
      end
      if (k < 8)
        chk_cyc(n, SS - 1, SS + 1);
    end
    chk_bit(ss_step === 4'h8, 1'b1);
    // fall to fall of the high side is one period; the duty cap leaves a gap
    wait_on(3, 1'b1, PP + RF, n);
    wait_on(3, 1'b0, PP, n);
    for (k = 0; k < 3; k = k + 1) begin
      wait_on(3, 1'b1, PP, n);
      wait_on(3, 1'b0, PP, r);
      chk_cyc(n + r, PP, PP);
      chk_cyc(n, 1, RF + 2);
    end
    t0 = cyc;
    // count recharge pulses while the bootstrap droops under near-full duty
    r = 0;
    n = 0;
    repeat (30 * PP) begin
      tick;
      n = (ls === 1'b1) ? n + 1 : 0;
      if (ls !== 1'b1 && (n == 0) && k >= RF && k <= RF + 1)
        r = r + 1;
      k = n;
    end
    chk_cyc(r, 3, 12);
    // a peak trip keeps the high side off until the next period starts
    wait_on(3, 1'b1, PP + RF + 2, n);
    rnd_wait;
    poc = 1'b1;
    repeat (2) tick;
    poc = 1'b0;
    wait_on(3, 1'b0, 4, n);
    wait_on(3, 1'b1, PP, n);
    chk_cyc((cyc - t0 + 2) % PP, 0, RF + 4);
    ear = 1'b0;
    count_hs(r);
    chk_cyc(r, 0, 0);
    rnd_wait;
    uc = 1'b1;
    repeat (2) tick;
    uc = 1'b0;
    wait_on(4, 1'b0, 4, n);
    wait_on(4, 1'b1, PP, n);
    chk_cyc((cyc - t0 + 2) % PP, 0, 4);
    ear = 1'b1;
    aoc = 1'b1;
    count_hs(r);
    chk_cyc(r, 0, 0);
    aoc = 1'b0;
    wait_on(3, 1'b1, PP + RF + 4, n);
    chk_bit(fix_sel, 1'b0);
    cll = 1'b1;
    repeat (4) tick;
    chk_bit(fix_sel, 1'b1);
    // each of the seven set_cond stop causes ends charging; adapter-good loss is not driven here; a cleared cause lets it ramp again, hot only after cool
    for (k = 0; k < 7; k = k + 1) begin
      set_cond(k, 1'b1);
      wait_on(2, 1'b0, 6, n);
      chk_cyc(n, 1, 5);
      // hold the cause a little longer so the port assertions see it settle
      repeat (2) tick;
      set_cond(k, 1'b0);
      if (k == 6) begin
        repeat (AD + AG + 20) tick;
        chk_bit(chg, 1'b0);
        chk_bit(gd_en, 1'b0);
        cool = 1'b1;
      end
      wait_on(2, 1'b1, AD + AG + 40, n);
      chk_bit(ss_step === 4'h1, 1'b1);
    end
    {a06, a24} = 2'h0;
    repeat (6) tick;
    chk_bit(mon_en, 1'b0);
    chk_bit(good, 1'b0);
    {s4, s45} = 2'h0;
    repeat (6) tick;
    chk_bit(ref_en, 1'b0);
    end_sim;
  end
endmodule
bind charger_ctrl charger_ctrl_properties i_charger_ctrl_properties (.clock_i(clock_i),
  .nrst_i(nrst_i), .supply_above_4v_i(supply_above_4v_i),
  .adapter_above_0v6_i(adapter_above_0v6_i), .charge_allow_i(charge_allow_i),
  .die_above_155c_i(die_above_155c_i), .avg_overcurrent_i(avg_overcurrent_i),
  .current_monitor_en_o(current_monitor_en_o), .gate_drive_enable_o(gate_drive_enable_o),
  .charging_o(charging_o), .soft_start_step_o(soft_start_step_o),
  .high_side_on_o(high_side_on_o), .low_side_on_o(low_side_on_o));
